/* File: rtl/memchk_regs.svh */
// constants of the memory checker block
`ifndef MEMCHK_REGS_SVH
`define MEMCHK_REGS_SVH
`define MEMCHK_SIG_W 32
`define MEMCHK_DAT_W 16
`define MEMCHK_CNT_W 16
`define MEMCHK_SEED_RST 32'hffffffff
`define MEMCHK_POLY_RST 32'h04c11db7
`define MEMCHK_CNT_RST 16'h0000
`endif

/* File: rtl/memchk_pkg.sv */
// types of the memory checker block
package memchk_pkg;
  typedef enum logic [0:0] {MEMCHK_RUN, MEMCHK_CHECK} memchk_state_type;
endpackage

/* File: rtl/memchk_buf.sv */
// two-entry valid/ready buffer in front of the signature engine
`timescale 1ns/1ps
module memchk_buf #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  logic [W-1:0] mem_ff [2];
  logic [W-1:0] nxt_mem [2];
  logic rd_ff, nxt_rd, wr_ff, nxt_wr;
  logic [1:0] cnt_ff, nxt_cnt;
  logic push, pop;

  // occupancy and pointer update; ready falls only when both slots are taken
  always_comb begin
    push = in_valid && (cnt_ff != 2'h2);
    pop = out_ready && (cnt_ff != 2'h0);
    nxt_mem = mem_ff;
    nxt_wr = wr_ff;
    nxt_rd = rd_ff;
    if (push) begin
      nxt_mem[wr_ff] = in_data;
      nxt_wr = ~wr_ff;
    end
    if (pop) begin
      nxt_rd = ~rd_ff;
    end
    nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      mem_ff[0] <= '0;
      mem_ff[1] <= '0;
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      cnt_ff <= 2'h0;
    end else begin
      mem_ff <= nxt_mem;
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  assign in_ready = (cnt_ff != 2'h2);
  assign out_valid = (cnt_ff != 2'h0);
  assign out_data = mem_ff[rd_ff];

  a_buf_no_overflow: assert property (@(posedge clk) disable iff (!rstn) cnt_ff <= 2'h2)
    else $error("buffer count above two");
endmodule

/* File: rtl/memchk_top.sv */
// memory checker: crc signature engine with block counter and comparator
`timescale 1ns/1ps
`include "memchk_regs.svh"
module memchk_top #(
  parameter int CNT_W = `MEMCHK_CNT_W
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // configuration
  input wire logic [31:0] POLY,
  input wire logic [31:0] SEED,
  input wire logic [31:0] EXPECT,
  input wire logic [CNT_W-1:0] BLOCK_LEN,
  input wire logic CMP_EN,
  input wire logic IRQ_EN,
  input wire logic ERR_CLR,
  input wire logic RESTART,
  // data stream
  input wire logic DIN_VALID,
  input wire logic [15:0] DIN,
  output logic DIN_READY,
  // results
  output logic [31:0] SIGNATURE,
  output logic [31:0] RESULT,
  output logic DONE,
  output logic ERR,
  output logic IRQ,
  output logic [CNT_W-1:0] WORDS_LEFT
);
  logic buf_valid;
  logic [15:0] buf_data;
  logic buf_ready;
  logic in_ready;
  logic fill;
  memchk_pkg::memchk_state_type state_ff, nxt_state;
  logic [31:0] sig_ff, nxt_sig, res_ff, nxt_res;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic done_ff, nxt_done, err_ff, nxt_err, irq_ff, nxt_irq, rdy_ff, nxt_rdy;
  logic [31:0] fold;
  logic take, mismatch;
  logic [CNT_W-1:0] len_eff;

  // two-entry buffer absorbs words while the engine spends a cycle comparing
  memchk_buf #(.W(16)) u_buf (
    .clk(CLK),
    .rstn(RSTN),
    .in_valid(fill),
    .in_data(DIN),
    .in_ready(in_ready),
    .out_valid(buf_valid),
    .out_data(buf_data),
    .out_ready(buf_ready)
  );

  // sixteen serial division steps unrolled into one combinational fold
  always_comb begin
    logic [31:0] s;
    s = sig_ff;
    for (int i = 15; i >= 0; i--) begin
      if (s[31] ^ buf_data[i]) begin
        s = {s[30:0], 1'b0} ^ POLY;
      end else begin
        s = {s[30:0], 1'b0};
      end
    end
    fold = s;
  end

  // zero length would never end a block, so treat it as one word
  assign len_eff = (BLOCK_LEN == '0) ? {{(CNT_W-1){1'b0}}, 1'b1} : BLOCK_LEN;
  assign buf_ready = (state_ff == memchk_pkg::MEMCHK_RUN) && !RESTART;
  assign take = buf_ready && buf_valid;
  assign mismatch = CMP_EN && (sig_ff != EXPECT);

  // the buffer fills only while the registered ready is shown, so both sides agree on every transfer
  assign fill = DIN_VALID && rdy_ff;

  // block sequencing, comparator and sticky error flag
  always_comb begin
    nxt_state = state_ff;
    nxt_sig = sig_ff;
    nxt_cnt = cnt_ff;
    nxt_res = res_ff;
    nxt_done = 1'b0;
    nxt_err = err_ff;
    nxt_irq = 1'b0;
    // ready is registered, so predict whether the buffer will be full after this edge
    nxt_rdy = take || !(buf_valid && (!in_ready || fill));
    if (ERR_CLR) begin
      nxt_err = 1'b0;
    end
    if (RESTART) begin
      nxt_state = memchk_pkg::MEMCHK_RUN;
      nxt_sig = SEED;
      nxt_cnt = len_eff;
    end else begin
      case (state_ff)
        memchk_pkg::MEMCHK_RUN: begin
          if (take) begin
            nxt_sig = fold;
            nxt_cnt = cnt_ff - {{(CNT_W-1){1'b0}}, 1'b1};
            if (cnt_ff == {{(CNT_W-1){1'b0}}, 1'b1}) begin
              nxt_state = memchk_pkg::MEMCHK_CHECK;
            end
          end
        end
        memchk_pkg::MEMCHK_CHECK: begin
          nxt_res = sig_ff;
          nxt_done = 1'b1;
          if (mismatch) begin
            nxt_err = 1'b1;
            nxt_irq = IRQ_EN;
          end
          nxt_sig = SEED;
          nxt_cnt = len_eff;
          nxt_state = memchk_pkg::MEMCHK_RUN;
        end
        default: begin
          nxt_state = memchk_pkg::MEMCHK_RUN;
        end
      endcase
    end
  end

  // state registers; reset clears the counter, which loads the block length on a restart or a block end
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      state_ff <= memchk_pkg::MEMCHK_RUN;
      sig_ff <= `MEMCHK_SEED_RST;
      cnt_ff <= `MEMCHK_CNT_RST;
      res_ff <= '0;
      done_ff <= 1'b0;
      err_ff <= 1'b0;
      irq_ff <= 1'b0;
      rdy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      sig_ff <= nxt_sig;
      cnt_ff <= nxt_cnt;
      res_ff <= nxt_res;
      done_ff <= nxt_done;
      err_ff <= nxt_err;
      irq_ff <= nxt_irq;
      rdy_ff <= nxt_rdy;
    end
  end

  // outputs straight from flip-flops
  assign SIGNATURE = sig_ff;
  assign RESULT = res_ff;
  assign DONE = done_ff;
  assign ERR = err_ff;
  assign IRQ = irq_ff;
  assign WORDS_LEFT = cnt_ff;
  assign DIN_READY = rdy_ff;

  // checks on the engine; all run on the system clock and rest while reset is held

  // an accepted word lands in the signature one edge later
  a_fold_on_take: assert property (@(posedge CLK) disable iff (!RSTN)
    (take && !RESTART) |=> (sig_ff == $past(fold)))
    else $error("signature did not fold accepted word");

  // every accepted word uses up one count of the block
  a_count_down: assert property (@(posedge CLK) disable iff (!RSTN)
    (take && !RESTART) |=> (cnt_ff == $past(cnt_ff) - 1'b1))
    else $error("block counter did not step");

  // last word, one cycle of compare, then the done pulse
  a_block_end: assert property (@(posedge CLK) disable iff (!RSTN)
    (take && !RESTART && cnt_ff == 1) |=> ##1 DONE)
    else $error("block end did not produce done");

  // a failed compare sets the sticky flag even against a clear in the same cycle
  a_err_set: assert property (@(posedge CLK) disable iff (!RSTN)
    (state_ff == memchk_pkg::MEMCHK_CHECK && !RESTART && mismatch) |=> ERR)
    else $error("mismatch did not set error");

  // the interrupt only follows a failed compare that was allowed to signal
  a_irq_cause: assert property (@(posedge CLK) disable iff (!RSTN)
    IRQ |-> ($past(mismatch) && $past(IRQ_EN) && !$past(RESTART) && $past(state_ff) == memchk_pkg::MEMCHK_CHECK))
    else $error("interrupt without failed check");

  // a newly raised error must belong to a result that differs from the expected value
  a_cmp_result: assert property (@(posedge CLK) disable iff (!RSTN)
    (DONE && ERR && !$past(ERR) && CMP_EN) |-> (RESULT != EXPECT))
    else $error("error set although signature matched");

  // the next block starts from the seed with a full count
  a_reload: assert property (@(posedge CLK) disable iff (!RSTN)
    (state_ff == memchk_pkg::MEMCHK_CHECK && !RESTART) |=> (cnt_ff == $past(len_eff) && sig_ff == $past(SEED)))
    else $error("counter or seed not reloaded after block");

  // from a zero signature only the last data bit feeds back, so the fold yields the polynomial itself
  a_poly_used: assert property (@(posedge CLK) disable iff (!RSTN)
    (take && !RESTART && sig_ff == 32'h00000000 && buf_data == 16'h0001) |=> (sig_ff == $past(POLY)))
    else $error("polynomial not applied");

  // the signature only moves on a fold, a restart or a block end
  a_sig_visible: assert property (@(posedge CLK) disable iff (!RSTN)
    (state_ff == memchk_pkg::MEMCHK_RUN && !take && !RESTART) |=> $stable(SIGNATURE))
    else $error("signature moved without a word");

  // a shown ready always has a free slot behind it, so no word is dropped
  a_ready_room: assert property (@(posedge CLK) disable iff (!RSTN)
    DIN_READY |-> in_ready)
    else $error("ready shown while buffer full");

  // done marks one block end, never two in a row
  a_done_pulse: assert property (@(posedge CLK) disable iff (!RSTN)
    DONE |=> !DONE)
    else $error("done longer than one cycle");

  // an interrupt always comes with the error flag raised
  a_irq_with_err: assert property (@(posedge CLK) disable iff (!RSTN)
    IRQ |-> ERR)
    else $error("interrupt without error flag");

  // the block result only changes together with done
  a_result_hold: assert property (@(posedge CLK) disable iff (!RSTN)
    !DONE |-> $stable(RESULT))
    else $error("result changed outside block end");
endmodule

/* File: test/memchk_src.sv */
// data source model standing in for the processor that feeds words
`timescale 1ns/1ps
module memchk_src (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // stream
  input wire logic stall,
  input wire logic din_ready,
  output logic din_valid,
  output logic [15:0] din
);
  logic [15:0] q[$];
  logic tk;
  // bench fills the word queue
  task automatic push(input logic [15:0] w);
    q.push_back(w);
  endtask
  // a word stays put until taken; an idle bus inverts every cycle, alternating between the old word and its inverse
  initial begin
    din_valid = 1'b0;
    din = 16'h0000;
    forever begin
      @(posedge clk);
      tk = din_valid && din_ready;
      if (tk) void'(q.pop_front());
      #1;
      if (tk || !din_valid) begin
        din_valid = rstn && !stall && din_ready && q.size() > 0;
        din = din_valid ? q[0] : ~din;
      end
    end
  end
endmodule

/* File: test/tb_memory_block_crc_checker.sv */
// self-checking bench for the memory checker block
`timescale 1ns/1ps
module tb_memory_block_crc_checker;
  logic clk, rstn, cmp_en, irq_en, err_clr, restart, stall, stall_on, din_valid, din_ready, done, err, irq;
  logic [31:0] poly, seed, expect_v, signature, result, lf, sr;
  logic [15:0] block_len, din, words_left;
  int error_cnt, samples_checked;
  memchk_top uut (.CLK(clk), .RSTN(rstn), .POLY(poly), .SEED(seed), .EXPECT(expect_v), .BLOCK_LEN(block_len),
    .CMP_EN(cmp_en), .IRQ_EN(irq_en), .ERR_CLR(err_clr), .RESTART(restart), .DIN_VALID(din_valid), .DIN(din),
    .DIN_READY(din_ready), .SIGNATURE(signature), .RESULT(result), .DONE(done), .ERR(err), .IRQ(irq),
    .WORDS_LEFT(words_left));
  memchk_src src (.clk(clk), .rstn(rstn), .stall(stall), .din_ready(din_ready), .din_valid(din_valid), .din(din));
  function automatic logic [31:0] nxt_rnd(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // msb-first fold, no reflection, no final xor
  function automatic logic [31:0] fold(input logic [31:0] s, input logic [15:0] d, input logic [31:0] p);
    for (int i = 15; i >= 0; i--) s = {s[30:0], 1'b0} ^ ((s[31] ^ d[i]) ? p : 32'h00000000);
    return s;
  endfunction
  task automatic check(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask
  task automatic final_report();
    if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  // one block: optional restart, a fixed first word then random words, then check result and flags
  task automatic run_block(input logic [15:0] bl, input logic [31:0] p, input logic mt, input logic ce,
      input logic ie, input logic rs);
    logic [31:0] e;
    logic [15:0] w;
    logic [15:0] n;
    int k;
    e = seed;
    n = (bl == 16'h0000) ? 16'h0001 : bl;
    poly = p;
    block_len = bl;
    cmp_en = ce;
    irq_en = ie;
    if (rs) begin
      restart = 1'b1;
      step();
      restart = 1'b0;
      check(signature === seed && words_left === n && din_ready === 1'b1, "restart load");
    end
    for (int i = 0; i < n; i++) begin
      lf = nxt_rnd(lf);
      w = (i == 0) ? ((seed == 32'h00000000) ? 16'h0001 : 16'hffff) : lf[15:0];
      e = fold(e, w, p);
      src.push(w);
    end
    expect_v = mt ? e : ~e;
    k = 0;
    while (done !== 1'b1 && k < 300) begin
      step();
      k++;
    end
    check(done === 1'b1, "block never finished");
    check(result === e, "block result");
    check(irq === (ie && ce && !mt), "irq");
    check(signature === seed && words_left === n, "reload after block");
    step();
    check(err === (ce && !mt), "err flag");
    check(done === 1'b0 && irq === 1'b0, "pulse width");
    if (err === 1'b1) begin
      err_clr = 1'b1;
      step();
      err_clr = 1'b0;
      step();
      check(err === 1'b0, "err clear");
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // partner stalls at random; negedge keeps it clear of the source's own updates
  always @(negedge clk) begin
    sr = nxt_rnd(sr);
    stall = stall_on & sr[2];
  end
  initial begin
    #200000;
    error_cnt++;
    final_report();
  end
  initial begin
    {rstn, cmp_en, irq_en, err_clr, restart, stall_on} = 6'h00;
    poly = 32'h04c11db7;
    seed = 32'hffffffff;
    expect_v = 32'h00000000;
    block_len = 16'h0001;
    lf = 32'h8d6e;
    sr = 32'h8d6e;
    repeat (4) @(posedge clk);
    #1;
    check(signature === 32'hffffffff && words_left === 16'h0000 && err === 1'b0, "reset");
    check(done === 1'b0 && irq === 1'b0 && din_ready === 1'b0, "reset flags");
    rstn = 1'b1;
    run_block(16'h0001, 32'h04c11db7, 1'b1, 1'b1, 1'b1, 1'b1);
    run_block(16'h0000, 32'h1edc6f41, 1'b0, 1'b1, 1'b1, 1'b1);
    run_block(16'h0007, 32'h814141ab, 1'b0, 1'b1, 1'b0, 1'b1);
    for (int j = 0; j < 4; j++) begin
      lf = nxt_rnd(lf);
      seed = lf;
      run_block(16'h0010, lf | 32'h00000001, j[0], 1'b1, 1'b1, 1'b1);
    end
    // zero seed with a lone low bit makes the fold equal the polynomial
    seed = 32'h00000000;
    run_block(16'h0003, 32'h1edc6f41, 1'b1, 1'b1, 1'b0, 1'b1);
    stall_on = 1'b1;
    run_block(16'h0014, 32'h04c11db7, 1'b1, 1'b1, 1'b1, 1'b1);
    run_block(16'h0014, 32'h04c11db7, 1'b0, 1'b0, 1'b1, 1'b0);
    final_report();
  end
endmodule
